/* File: su_top.sv */
// Serial port top: Avalon-MM register slave, UART transmitter, receive
// buffering and error status, and two 3-wire clocked channels.
// Assumes one 25 MHz clock; all pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Reset leaves transmitter empty, no completion pulse
// - Receive enable starts sampling on selected clock
// - Low input restarts counter, rechecked at m
// - Frame end loads buffer, pulses completion
// - Error frames buffered; completion gated by suppress
// - Receive disable aborts, buffer and status kept
// - Receive error sets flag, pulses error output
// - Parity, framing and overrun errors detected
// - Buffer read or next frame clears flags
// - One shared 8-bit shift register per channel
// - Output latch holds the data pin level
// - Clock counter pulses done after eight clocks
// - Shift input from pin or output latch
// - Clocked mode registers 8-bit, reset to zero
// - Eight-bit transfers, direction bit picks order
// - Output changes on fall, input sampled rising
// - Transfer done on eighth rising edge
// - Internal clock stops high after eighth rise
// - Both UART enables clear selects 3-wire mode on channel A
// - Second unread frame sets overrun, replaces others
module su_top #(
	parameter int DIV_W = 16,
	parameter int M_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [5:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWriteData,
	input wire logic [3:0] avByteEnable,
	output logic [31:0] avReadData,
	output logic avWaitRequest,
	input wire logic [DIV_W-1:0] baudDiv,
	input wire logic [M_W-1:0] sampleM,
	input wire logic [DIV_W-1:0] csiDiv,
	input wire logic uartRxdPin,
	output logic uartTxdPin,
	input wire logic uartExtClkPin,
	input wire logic [1:0] csiSckIn,
	output logic [1:0] csiSckOut,
	output logic [1:0] csiSckOe,
	input wire logic [1:0] csiSdiPin,
	output logic [1:0] csiSdoPin,
	output logic uartTxDoneIrq,
	output logic uartRxDoneIrq,
	output logic uartRxErrorIrq,
	output logic [1:0] csiXferDoneIrq
);
	logic ack_reg;
	logic [31:0] readData_reg;
	logic doRead;
	logic doWrite;
	logic [7:0] rdMux;
	logic [7:0] uartMode_reg;
	logic [7:0] clockedMode_reg [2];
	logic [7:0] uartRxBuffer_reg;
	logic [7:0] uartErrorStatus_reg;
	logic rxFull_reg;
	logic [5:0] syncA_reg;
	logic [5:0] syncB_reg;
	logic extPrev_reg;
	logic [DIV_W-1:0] baudCnt_reg;
	logic [DIV_W-1:0] csiCnt_reg;
	logic baudTick;
	logic csiTick;
	logic uartTick;
	logic [11:0] txFrame_reg;
	logic [3:0] txLeft_reg;
	logic [M_W:0] txCnt_reg;
	logic txBusy;
	logic uartOff;
	logic [1:0] csiTx;
	logic [1:0] csiRx;
	logic [1:0] csiRxPrev_reg;
	logic [1:0] csiBusy;
	logic [7:0] csiData [2];
	logic [1:0] sioWr;
	logic [1:0] sioRd;
	logic rxDone;
	logic [7:0] rxData;
	logic rxParErr;
	logic rxFrmErr;
	logic rxBusy;
	logic [7:0] newErr;

	// Build a transmit frame: start, data LSB first, optional parity, stop bits
	function automatic logic [11:0] tx_frame(input logic [7:0] d, input logic [7:0] mode);
		logic [11:0] f;
		logic len8;
		len8 = mode[su_pkg::MODE_CL];
		f = 12'hfff;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < 7 || len8) begin
				f[i+1] = d[i];
			end
		end
		if (mode[su_pkg::MODE_PS+1 -: 2] != su_pkg::PAR_NONE) begin
			f[len8 ? 9 : 8] = su_pkg::par_bit(d, len8, mode[su_pkg::MODE_PS+1 -: 2]);
		end
		tx_frame = f;
	endfunction

	// Bit count of a frame from the mode bits
	function automatic logic [3:0] tx_len(input logic [7:0] mode);
		tx_len = 4'h9 + {3'h0, mode[su_pkg::MODE_CL]} + {3'h0, mode[su_pkg::MODE_SL]}
			+ {3'h0, mode[su_pkg::MODE_PS+1 -: 2] != su_pkg::PAR_NONE};
	endfunction

	// One wait state per access keeps read data a flop output
	assign avWaitRequest = (avRead | avWrite) & ~ack_reg;
	assign doRead = avRead & ack_reg;
	assign doWrite = avWrite & ack_reg & avByteEnable[0];
	assign avReadData = readData_reg;
	assign uartOff = ~uartMode_reg[su_pkg::MODE_TXE] & ~uartMode_reg[su_pkg::MODE_RXE];
	assign txBusy = (txLeft_reg != 4'h0);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avRead | avWrite) & ~ack_reg;
		end
	end

	// Read mux; unmapped offsets and upper bits read as zero
	always_comb begin
		case (avAddress)
			su_pkg::OFF_MODE: rdMux = uartMode_reg;
			su_pkg::OFF_RXBUF: rdMux = uartRxBuffer_reg;
			su_pkg::OFF_ERRSTAT: rdMux = uartErrorStatus_reg;
			su_pkg::OFF_CSIM_A: rdMux = clockedMode_reg[0];
			su_pkg::OFF_CSIM_B: rdMux = clockedMode_reg[1];
			su_pkg::OFF_SIO_A: rdMux = csiData[0];
			su_pkg::OFF_SIO_B: rdMux = csiData[1];
			su_pkg::OFF_STATUS: rdMux = {3'h0, syncB_reg[0], csiBusy, rxBusy, txBusy};
			default: rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			readData_reg <= 32'h0000_0000;
		end else if (avRead && !ack_reg) begin
			readData_reg <= {24'h00_0000, rdMux};
		end
	end

	// Mode registers, byte writes only on lane zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uartMode_reg <= su_pkg::MODE_RESET;
			clockedMode_reg[0] <= su_pkg::CSIM_RESET;
			clockedMode_reg[1] <= su_pkg::CSIM_RESET;
		end else if (doWrite) begin
			if (avAddress == su_pkg::OFF_MODE) begin
				uartMode_reg <= avWriteData[7:0];
			end
			if (avAddress == su_pkg::OFF_CSIM_A) begin
				clockedMode_reg[0] <= avWriteData[7:0];
			end
			if (avAddress == su_pkg::OFF_CSIM_B) begin
				clockedMode_reg[1] <= avWriteData[7:0];
			end
		end
	end

	// Pin synchronisers: rxd, external baud clock, two sck, two sdi
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= 6'h3f;
			syncB_reg <= 6'h3f;
			extPrev_reg <= 1'b1;
		end else begin
			syncA_reg <= {csiSdiPin, csiSckIn, uartExtClkPin, uartRxdPin};
			syncB_reg <= syncA_reg;
			extPrev_reg <= syncB_reg[1];
		end
	end

	// Dividers from the configuration inputs; zero is treated as one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			baudCnt_reg <= '0;
		end else if (baudTick) begin
			baudCnt_reg <= '0;
		end else begin
			baudCnt_reg <= baudCnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			csiCnt_reg <= '0;
		end else if (csiTick) begin
			csiCnt_reg <= '0;
		end else begin
			csiCnt_reg <= csiCnt_reg + 1'b1;
		end
	end

	assign baudTick = (baudCnt_reg + 1'b1 >= baudDiv);
	assign csiTick = (csiCnt_reg + 1'b1 >= csiDiv);
	// Clock source bit picks internal divider or external clock rising edge
	assign uartTick = uartMode_reg[su_pkg::MODE_CLKSEL] ? baudTick : (syncB_reg[1] & ~extPrev_reg);

	// Transmitter; busy writes are dropped, clearing enable aborts quietly
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txFrame_reg <= 12'hfff;
			txLeft_reg <= 4'h0;
			txCnt_reg <= '0;
			uartTxDoneIrq <= 1'b0;
		end else begin
			uartTxDoneIrq <= 1'b0;
			if (!uartMode_reg[su_pkg::MODE_TXE]) begin
				txLeft_reg <= 4'h0;
				txFrame_reg <= 12'hfff;
			end else if (!txBusy) begin
				if (doWrite && avAddress == su_pkg::OFF_TXDATA) begin
					txFrame_reg <= tx_frame(avWriteData[7:0], uartMode_reg);
					txLeft_reg <= tx_len(uartMode_reg);
					txCnt_reg <= '0;
				end
			end else if (uartTick) begin
				if (txCnt_reg + 1'b1 == {sampleM, 1'b0}) begin
					txCnt_reg <= '0;
					txFrame_reg <= {1'b1, txFrame_reg[11:1]};
					txLeft_reg <= txLeft_reg - 4'h1;
					uartTxDoneIrq <= (txLeft_reg == 4'h1);
				end else begin
					txCnt_reg <= txCnt_reg + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uartTxdPin <= 1'b1;
		end else begin
			uartTxdPin <= txFrame_reg[0];
		end
	end

	su_uart_rx #(
		.M_W(M_W)
	) u_rx (
		.clk(clk),
		.arst_n(arst_n),
		.tick(uartTick),
		.enable(uartMode_reg[su_pkg::MODE_RXE]),
		.rxd(syncB_reg[0]),
		.sampleM(sampleM),
		.charLen8(uartMode_reg[su_pkg::MODE_CL]),
		.parMode(uartMode_reg[su_pkg::MODE_PS+1 -: 2]),
		.frameDone(rxDone),
		.dataOut(rxData),
		.parityErr(rxParErr),
		.framingErr(rxFrmErr),
		.busy(rxBusy)
	);

	// New status replaces the old one whole; overrun means previous unread
	assign newErr = {5'h00, rxParErr, rxFrmErr, rxFull_reg};

	// Receive buffer and error status; a frame arriving with a read wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uartRxBuffer_reg <= 8'h00;
			uartErrorStatus_reg <= su_pkg::ERR_RESET;
			rxFull_reg <= 1'b0;
		end else if (rxDone) begin
			uartRxBuffer_reg <= rxData;
			uartErrorStatus_reg <= newErr;
			rxFull_reg <= 1'b1;
		end else if (doRead && avAddress == su_pkg::OFF_RXBUF) begin
			uartErrorStatus_reg <= su_pkg::ERR_RESET;
			rxFull_reg <= 1'b0;
		end
	end

	// Completion withheld for errored frames while suppress is set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uartRxDoneIrq <= 1'b0;
			uartRxErrorIrq <= 1'b0;
		end else begin
			uartRxDoneIrq <= rxDone && (newErr == 8'h00 || !uartMode_reg[su_pkg::MODE_RX_ERROR_IRQ_SUPPRESS]);
			uartRxErrorIrq <= rxDone && (newErr != 8'h00);
		end
	end

	// Enable history for the receive-enable rising start
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			csiRxPrev_reg <= 2'h0;
		end else begin
			csiRxPrev_reg <= csiRx;
		end
	end

	// Two clocked channels; channel A shares the port with the UART
	for (genvar ch = 0; ch < 2; ch++) begin : g_csi
		assign csiTx[ch] = clockedMode_reg[ch][su_pkg::CSIM_CTXE] & (ch == 1 || uartOff);
		assign csiRx[ch] = clockedMode_reg[ch][su_pkg::CSIM_CRXE] & (ch == 1 || uartOff);
		assign sioWr[ch] = doWrite && avAddress == (ch == 0 ? su_pkg::OFF_SIO_A : su_pkg::OFF_SIO_B);
		assign sioRd[ch] = doRead && avAddress == (ch == 0 ? su_pkg::OFF_SIO_A : su_pkg::OFF_SIO_B);

		su_csi_shift u_csi (
			.clk(clk),
			.arst_n(arst_n),
			.tick(csiTick),
			.txEn(csiTx[ch]),
			.rxEn(csiRx[ch]),
			.lsbFirst(clockedMode_reg[ch][su_pkg::CSIM_DIR]),
			.intClk(clockedMode_reg[ch][su_pkg::CSIM_CLKSEL]),
			.load(sioWr[ch]),
			.loadData(avWriteData[7:0]),
			.start((sioWr[ch] & csiTx[ch]) | (sioRd[ch] & csiRx[ch] & ~csiTx[ch])
				| (csiRx[ch] & ~csiRxPrev_reg[ch])),
			.sckIn(syncB_reg[2+ch]),
			.sdi(syncB_reg[4+ch]),
			.shiftData(csiData[ch]),
			.sckOut(csiSckOut[ch]),
			.sckOe(csiSckOe[ch]),
			.sdoOut(csiSdoPin[ch]),
			.xferDone(csiXferDoneIrq[ch]),
			.busy(csiBusy[ch])
		);
	end
endmodule
`default_nettype wire

/* File: su_pkg.sv */
// Shared constants for the serial port: register offsets, field positions,
// reset values and the parity helper.
// Assumes a 32-bit Avalon-MM slave with byte addresses and 8-bit registers.
package su_pkg;
	// Register byte offsets, one aligned word each
	localparam logic [5:0] OFF_MODE = 6'h00;
	localparam logic [5:0] OFF_TXDATA = 6'h04;
	localparam logic [5:0] OFF_RXBUF = 6'h08;
	localparam logic [5:0] OFF_ERRSTAT = 6'h0c;
	localparam logic [5:0] OFF_CSIM_A = 6'h10;
	localparam logic [5:0] OFF_CSIM_B = 6'h14;
	localparam logic [5:0] OFF_SIO_A = 6'h18;
	localparam logic [5:0] OFF_SIO_B = 6'h1c;
	localparam logic [5:0] OFF_STATUS = 6'h20;
	// UART mode register fields
	localparam int MODE_CLKSEL = 0;
	localparam int MODE_RX_ERROR_IRQ_SUPPRESS = 1;
	localparam int MODE_SL = 2;
	localparam int MODE_CL = 3;
	localparam int MODE_PS = 4;
	localparam int MODE_RXE = 6;
	localparam int MODE_TXE = 7;
	// Clocked mode register fields
	localparam int CSIM_CLKSEL = 0;
	localparam int CSIM_DIR = 2;
	localparam int CSIM_CRXE = 6;
	localparam int CSIM_CTXE = 7;
	// Error status fields
	localparam int ERR_OVR = 0;
	localparam int ERR_FRM = 1;
	localparam int ERR_PAR = 2;
	// Status register fields
	localparam int ST_TXBUSY = 0;
	localparam int ST_RXBUSY = 1;
	localparam int ST_CSIBUSY = 2;
	localparam int ST_RXDLVL = 4;
	// Reset values
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CSIM_RESET = 8'h00;
	localparam logic [7:0] ERR_RESET = 8'h00;
	// Parity selections
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	// Expected parity bit for a 7- or 8-bit character
	function automatic logic par_bit(input logic [7:0] d, input logic len8, input logic [1:0] ps);
		logic ones;
		ones = len8 ? ^d : ^d[6:0];
		case (ps)
			PAR_ODD: par_bit = ~ones;
			PAR_EVEN: par_bit = ones;
			default: par_bit = 1'b0;
		endcase
	endfunction
endpackage

/* File: su_uart_rx.sv */
// UART receive engine: start detection, bit sampling and frame checks.
// Assumes tick is a one-cycle enable of the sampling clock and rxd is synchronised.
`timescale 1ns/1ps
`default_nettype none
module su_uart_rx #(
	parameter int M_W = 8
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic enable,
	input wire logic rxd,
	input wire logic [M_W-1:0] sampleM,
	input wire logic charLen8,
	input wire logic [1:0] parMode,
	output logic frameDone,
	output logic [7:0] dataOut,
	output logic parityErr,
	output logic framingErr,
	output logic busy
);
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} su_rx_state_e;

	su_rx_state_e state_reg;
	logic [M_W:0] cnt_reg;
	logic [3:0] bitIdx_reg;
	logic [7:0] shift_reg;
	logic [M_W:0] cntInc;
	logic halfHit;
	logic fullHit;
	logic [7:0] dataNow;

	// Start check at m, every later bit two m counts apart
	assign cntInc = cnt_reg + 1'b1;
	assign halfHit = tick && (cntInc == {1'b0, sampleM});
	assign fullHit = tick && (cntInc == {sampleM, 1'b0});
	assign dataNow = charLen8 ? shift_reg : {1'b0, shift_reg[7:1]};
	assign busy = (state_reg != RX_IDLE);

	// Frame sequencer; dropping enable abandons the frame with no result
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= RX_IDLE;
			cnt_reg <= '0;
			bitIdx_reg <= 4'h0;
			shift_reg <= 8'h00;
		end else if (!enable) begin
			state_reg <= RX_IDLE;
			cnt_reg <= '0;
		end else begin
			if (tick) begin
				cnt_reg <= cntInc;
			end
			case (state_reg)
				RX_IDLE: begin
					cnt_reg <= '0;
					if (!rxd) begin
						state_reg <= RX_START;
					end
				end
				RX_START: begin
					if (halfHit) begin
						cnt_reg <= '0;
						bitIdx_reg <= 4'h0;
						state_reg <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (fullHit) begin
						cnt_reg <= '0;
						shift_reg <= {rxd, shift_reg[7:1]};
						bitIdx_reg <= bitIdx_reg + 4'h1;
						if (bitIdx_reg == (charLen8 ? 4'h7 : 4'h6)) begin
							state_reg <= (parMode == su_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
						end
					end
				end
				RX_PAR: begin
					if (fullHit) begin
						cnt_reg <= '0;
						state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (fullHit) begin
						state_reg <= RX_IDLE;
					end
				end
				default: state_reg <= RX_IDLE;
			endcase
		end
	end

	// Result capture; parity held until the stop bit decides the frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frameDone <= 1'b0;
			dataOut <= 8'h00;
			parityErr <= 1'b0;
			framingErr <= 1'b0;
		end else begin
			frameDone <= 1'b0;
			if (enable && state_reg == RX_PAR && fullHit) begin
				parityErr <= (parMode[1] && (su_pkg::par_bit(dataNow, charLen8, parMode) != rxd));
			end else if (enable && state_reg == RX_DATA && bitIdx_reg == 4'h0 && fullHit) begin
				parityErr <= 1'b0;
			end
			if (enable && state_reg == RX_STOP && fullHit) begin
				frameDone <= 1'b1;
				dataOut <= dataNow;
				framingErr <= ~rxd;
			end
		end
	end
endmodule
`default_nettype wire

/* File: su_csi_shift.sv */
// One channel of the 3-wire clocked serial engine with shift register and output latch.
// Assumes tick is a half-period enable and sckIn, sdi are already synchronised.
`timescale 1ns/1ps
`default_nettype none
module su_csi_shift (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic tick,
	input wire logic txEn,
	input wire logic rxEn,
	input wire logic lsbFirst,
	input wire logic intClk,
	input wire logic load,
	input wire logic [7:0] loadData,
	input wire logic start,
	input wire logic sckIn,
	input wire logic sdi,
	output logic [7:0] shiftData,
	output logic sckOut,
	output logic sckOe,
	output logic sdoOut,
	output logic xferDone,
	output logic busy
);
	logic [3:0] cnt_reg;
	logic sckPrev_reg;
	logic active;
	logic fallEv;
	logic riseEv;
	logic shiftIn;

	assign active = txEn | rxEn;
	assign sckOe = intClk;
	// Edges come from our own divider or from the far end's clock
	assign fallEv = busy && (intClk ? (tick && sckOut) : (sckPrev_reg && !sckIn));
	assign riseEv = busy && (intClk ? (tick && !sckOut) : (!sckPrev_reg && sckIn));
	// Loop back the output latch when the input side is off
	assign shiftIn = rxEn ? sdi : sdoOut;

	// Edge history of the external clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sckPrev_reg <= 1'b1;
		end else begin
			sckPrev_reg <= sckIn;
		end
	end

	// Transfer control and the eight-clock counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			cnt_reg <= 4'h0;
			xferDone <= 1'b0;
			sckOut <= 1'b1;
		end else begin
			xferDone <= 1'b0;
			if (!active) begin
				busy <= 1'b0; // Aborted transfer raises nothing
				sckOut <= 1'b1;
			end else if (!busy) begin
				sckOut <= 1'b1;
				if (start) begin
					busy <= 1'b1;
					cnt_reg <= 4'h0;
				end
			end else begin
				if (intClk && tick) begin
					sckOut <= ~sckOut;
				end
				if (riseEv) begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h7) begin
						busy <= 1'b0;
						xferDone <= 1'b1;
					end
				end
			end
		end
	end

	// Shift register: loaded while idle, shifted on each rise
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			shiftData <= 8'h00;
		end else if (load && !busy) begin
			shiftData <= loadData;
		end else if (riseEv) begin
			shiftData <= lsbFirst ? {shiftIn, shiftData[7:1]} : {shiftData[6:0], shiftIn};
		end
	end

	// Output latch changes on falls, parks high when output is off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sdoOut <= 1'b1;
		end else if (!txEn) begin
			sdoOut <= 1'b1;
		end else if (fallEv) begin
			sdoOut <= lsbFirst ? shiftData[0] : shiftData[7];
		end
	end
endmodule
`default_nettype wire

/* File: su_top_properties.sv */
// Checker for the serial port top: bus wait state, pulse shapes, 3-wire clock.
// Assumes it is bound to su_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module su_props (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic avWaitRequest,
	input wire logic uartTxdPin,
	input wire logic [1:0] csiSckOut,
	input wire logic [1:0] csiSdoPin,
	input wire logic uartTxDoneIrq,
	input wire logic uartRxDoneIrq,
	input wire logic uartRxErrorIrq,
	input wire logic [1:0] csiXferDoneIrq
);
	logic [3:0] riseCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// Channel A clock rises since the last completion, so the pulse can be tied to the count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) riseCnt <= 4'h0;
		else if (csiXferDoneIrq[0]) riseCnt <= 4'h0;
		else if ($rose(csiSckOut[0])) riseCnt <= riseCnt + 4'h1;
	end
	a_bus_wait: assert property ($rose(avRead | avWrite) |-> avWaitRequest ##1 !avWaitRequest)
		else $error("bus wait state not exactly one cycle");
	a_tx_quiet: assert property ($rose(arst_n) |-> !uartTxDoneIrq [*8])
		else $error("transmit completion after reset");
	a_tx_end_high: assert property (uartTxDoneIrq |-> uartTxdPin && $past(uartTxdPin, 4))
		else $error("transmit completion before stop bit");
	a_rx_done_pulse: assert property (uartRxDoneIrq |=> !uartRxDoneIrq)
		else $error("receive completion longer than one cycle");
	a_rx_err_pulse: assert property (uartRxErrorIrq |=> !uartRxErrorIrq)
		else $error("receive error pulse longer than one cycle");
	a_xfer_eight: assert property (csiXferDoneIrq[0] |-> $rose(csiSckOut[0]) && riseCnt == 4'h7)
		else $error("transfer completion not after eight clock rises");
	a_sck_parked: assert property (csiXferDoneIrq[0] |-> csiSckOut[0] [*3])
		else $error("serial clock not parked high after transfer");
	a_sdo_on_fall: assert property ($changed(csiSdoPin[0]) && !csiSckOut[0] |-> $fell(csiSckOut[0]))
		else $error("data output changed away from clock fall");
endmodule
bind su_top su_props chk (.clk(clk), .arst_n(arst_n), .avRead(avRead), .avWrite(avWrite),
	.avWaitRequest(avWaitRequest), .uartTxdPin(uartTxdPin), .csiSckOut(csiSckOut), .csiSdoPin(csiSdoPin),
	.uartTxDoneIrq(uartTxDoneIrq), .uartRxDoneIrq(uartRxDoneIrq), .uartRxErrorIrq(uartRxErrorIrq),
	.csiXferDoneIrq(csiXferDoneIrq));
`default_nettype wire

/* File: su_peer.sv */
// Remote serial device: a UART sender and a clocked slave for channel A.
// Assumes the bench calls send between clock edges and sets reply between transfers.
`timescale 1ns/1ps
`default_nettype none
module su_peer #(
	parameter int BIT = 8
) (
	input wire logic clk,
	output logic rxd,
	input wire logic sck,
	input wire logic sdo,
	output logic sdi
);
	logic [7:0] reply;
	logic [7:0] got;
	initial begin
		rxd = 1'b1;
		sdi = 1'b1;
		reply = 8'h00;
		got = 8'h00;
	end
	// One frame, lsb first; the line is driven back high afterwards to idle
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxd <= bits[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= 1'b1;
	endtask
	// New bit on each fall; the reply rotates inverted so the next eight bits are its complement
	always @(negedge sck) begin
		sdi <= reply[7];
		reply <= {reply[6:0], ~reply[7]};
	end
	// Data from the block is taken on each rise
	always @(posedge sck) got <= {got[6:0], sdo};
endmodule
`default_nettype wire

/* File: su_top_test.sv */
// Self-checking bench for the serial port: register bus, UART both ways, 3-wire channel A.
// Assumes the remote peer on the UART receive pin and channel A; channel B idles.
`timescale 1ns/1ps
`default_nettype none
module su_top_test;
	localparam int M = 4;
	logic clk, arst_n, avRead, avWrite, avWaitRequest, uartTxdPin, rxd, sdiA, extClk;
	logic uartTxDoneIrq, uartRxDoneIrq, uartRxErrorIrq;
	logic [5:0] avAddress;
	logic [31:0] avWriteData, avReadData;
	logic [3:0] avByteEnable;
	logic [15:0] baudDiv, csiDiv;
	logic [7:0] sampleM;
	logic [1:0] csiSckIn, csiSckOut, csiSckOe, csiSdoPin, csiXferDoneIrq;
	int n_errors, checks, txDone, rxDone, rxErr, xDone;
	su_top uut (.clk(clk), .arst_n(arst_n), .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWriteData(avWriteData), .avByteEnable(avByteEnable), .avReadData(avReadData),
		.avWaitRequest(avWaitRequest), .baudDiv(baudDiv), .sampleM(sampleM), .csiDiv(csiDiv),
		.uartRxdPin(rxd), .uartTxdPin(uartTxdPin), .uartExtClkPin(extClk), .csiSckIn(csiSckIn),
		.csiSckOut(csiSckOut), .csiSckOe(csiSckOe), .csiSdiPin({1'b1, sdiA}), .csiSdoPin(csiSdoPin),
		.uartTxDoneIrq(uartTxDoneIrq), .uartRxDoneIrq(uartRxDoneIrq), .uartRxErrorIrq(uartRxErrorIrq),
		.csiXferDoneIrq(csiXferDoneIrq));
	su_peer #(.BIT(2 * M)) peer (.clk(clk), .rxd(rxd), .sck(csiSckOut[0]), .sdo(csiSdoPin[0]), .sdi(sdiA));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Pulse counters; the scenarios compare them against expected totals
	always @(posedge clk) begin
		if (uartTxDoneIrq === 1'b1) txDone++;
		if (uartRxDoneIrq === 1'b1) rxDone++;
		if (uartRxErrorIrq === 1'b1) rxErr++;
		if (csiXferDoneIrq[0] === 1'b1) xDone++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		avAddress <= a;
		avWriteData <= {24'h000000, d};
		avWrite <= wr;
		avRead <= !wr;
		do @(posedge clk); while (avWaitRequest !== 1'b0);
		q = avReadData[7:0];
		avWrite <= 1'b0;
		avRead <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic waitc(ref int c, input int old);
		for (int i = 0; i < 400 && c == old; i++) @(posedge clk);
		chk(8'(c - old), 8'h01);
	endtask
	// Frame of start, eight data bits, parity and stop, then time for the pulses to land
	task automatic rxf(input logic [7:0] d, input logic p, input logic s);
		peer.send({1'b1, s, p, d, 1'b0}, 11);
		repeat (2 * M) @(posedge clk);
	endtask
	task automatic t_reset;
		rd(su_pkg::OFF_MODE, su_pkg::MODE_RESET);
		rd(su_pkg::OFF_CSIM_A, su_pkg::CSIM_RESET);
		rd(su_pkg::OFF_ERRSTAT, su_pkg::ERR_RESET);
		wr(su_pkg::OFF_CSIM_B, 8'h85);
		rd(su_pkg::OFF_CSIM_B, 8'h85);
		wr(su_pkg::OFF_CSIM_B, 8'h00);
		rd(6'h24, 8'h00);
		chk(8'(txDone), 8'h00);
		$display("reset test finished");
	endtask
	task automatic t_tx;
		logic [9:0] f;
		f = {1'b1, 8'h5a, 1'b0};
		wr(su_pkg::OFF_MODE, 8'h89);
		wr(su_pkg::OFF_TXDATA, 8'h5a);
		while (uartTxdPin !== 1'b0) @(negedge clk);
		repeat (M) @(negedge clk);
		for (int i = 0; i < 10; i++) begin
			chk({7'h00, uartTxdPin}, {7'h00, f[i]});
			repeat (2 * M) @(negedge clk);
		end
		chk(8'(txDone), 8'h01);
		$display("transmit test finished");
	endtask
	task automatic t_rx;
		wr(su_pkg::OFF_MODE, 8'h79);
		rxf(8'ha5, 1'b0, 1'b1);
		rd(su_pkg::OFF_RXBUF, 8'ha5);
		rxf(8'h0f, 1'b1, 1'b1);
		chk(8'(rxErr), 8'h01);
		chk(8'(rxDone), 8'h02);
		rd(su_pkg::OFF_ERRSTAT, 8'h04);
		rxf(8'h3c, 1'b0, 1'b1);
		rd(su_pkg::OFF_ERRSTAT, 8'h01);
		rd(su_pkg::OFF_RXBUF, 8'h3c);
		rd(su_pkg::OFF_ERRSTAT, 8'h00);
		wr(su_pkg::OFF_MODE, 8'h7b);
		rxf(8'h01, 1'b0, 1'b1);
		rd(su_pkg::OFF_ERRSTAT, 8'h04);
		rd(su_pkg::OFF_RXBUF, 8'h01);
		// Missing stop bit is sent last: the low line may look like a new start
		rxf(8'h00, 1'b0, 1'b0);
		rd(su_pkg::OFF_ERRSTAT, 8'h02);
		rd(su_pkg::OFF_STATUS, 8'h10);
		chk(8'(rxDone), 8'h03);
		chk(8'(rxErr), 8'h04);
		$display("receive test finished");
	endtask
	task automatic t_abort;
		wr(su_pkg::OFF_MODE, 8'h39);
		wr(su_pkg::OFF_MODE, 8'h79);
		fork
			rxf(8'h55, 1'b0, 1'b1);
			begin
				repeat (40) @(posedge clk);
				wr(su_pkg::OFF_MODE, 8'h39);
			end
		join
		chk(8'(rxDone + rxErr), 8'h07);
		rd(su_pkg::OFF_ERRSTAT, 8'h02);
		rd(su_pkg::OFF_RXBUF, 8'h00);
		$display("abort test finished");
	endtask
	task automatic t_csi;
		int old;
		wr(su_pkg::OFF_MODE, 8'h00);
		peer.reply = 8'h96;
		wr(su_pkg::OFF_SIO_A, 8'h3a);
		old = xDone;
		wr(su_pkg::OFF_CSIM_A, 8'hc1);
		waitc(xDone, old);
		chk(peer.got, 8'h3a);
		chk({7'h00, csiSckOut[0]}, 8'h01);
		chk({7'h00, csiSckOe[0]}, 8'h01);
		rd(su_pkg::OFF_SIO_A, 8'h96);
		wr(su_pkg::OFF_CSIM_A, 8'hc5);
		peer.reply = 8'h96;
		old = xDone;
		wr(su_pkg::OFF_SIO_A, 8'h3a);
		waitc(xDone, old);
		chk(peer.got, 8'h5c);
		rd(su_pkg::OFF_SIO_A, 8'h69);
		wr(su_pkg::OFF_CSIM_A, 8'h81);
		old = xDone;
		wr(su_pkg::OFF_SIO_A, 8'hc3);
		waitc(xDone, old);
		chk(peer.got, 8'hc3);
		rd(su_pkg::OFF_SIO_A, 8'hc3);
		$display("clocked test finished");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop;
	end
	initial begin
		arst_n = 1'b0;
		avRead = 1'b0;
		avWrite = 1'b0;
		avAddress = 6'h00;
		avWriteData = 32'h00000000;
		avByteEnable = 4'hf;
		baudDiv = 16'h0001;
		sampleM = 8'(M);
		csiDiv = 16'h0004; // Half period must outlast the two-cycle pin sync
		extClk = 1'b0;
		csiSckIn = 2'h3;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		t_tx;
		t_rx;
		t_abort;
		t_csi;
		report_and_stop;
	end
endmodule
`default_nettype wire
